/* core/haptic_pattern_player.sv */
// Pattern memory, sample sequencer and trigger braking for the haptic driver.
//
// Functional notes
// - Trigger brake time is count times 5 ms.
// - Auto brake ends early, capped by duration.
// - Address register selects sample written afterward.
// - Chain code: last, more, interpolate, last-with-repeat.
// - Amplitude is 7-bit magnitude plus direction.
// - Sample drives for 5-bit duration, 5 ms steps.
// - Zero amplitude for wait time after sample.
// - Brake drives programmed amplitude, top bit sign.
`timescale 1ns/1ps
`include "haptic_pattern_consts.svh"
module haptic_pattern_player #(
    parameter int STEP_CYCLES = `STEP_CYCLES,
    parameter int DEPTH = 256
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic trigger_pin,
    input wire logic external_trigger_mode,
    input wire logic auto_brake_disable,
    input wire logic [7:0] trigger_brake_amplitude,
    input wire logic motion_stopped,
    output logic [6:0] drive_amplitude,
    output logic drive_negative,
    output logic braking,
    output logic busy
);
    logic [7:0] pattern_mem_address_q;
    logic [7:0] pattern_sample_upper_q;
    logic [7:0] pattern_sample_middle_q;
    logic [7:0] pattern_sample_lower_q;
    logic [7:0] trigger_brake_duration_q;
    logic [23:0] mem_q [DEPTH];
    haptic_pattern_pkg::play_state_t state_q;
    haptic_pattern_pkg::sample_t cur;
    haptic_pattern_pkg::sample_t nxt;
    logic [7:0] play_addr_q;
    logic [7:0] start_addr_q;
    logic [3:0] rep_q;
    logic [2:0] sync_q;
    logic trig_level_q;
    logic trig_rise;
    logic tmr_load;
    logic [7:0] tmr_steps;
    logic tmr_done;
    logic auto_stop;
    logic [7:0] cur_signed;
    logic [7:0] nxt_signed;
    logic [7:0] mid_signed;

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    // Software writes land on the register named by the offset.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pattern_mem_address_q <= `RST_REG8;
            pattern_sample_upper_q <= `RST_REG8;
            pattern_sample_middle_q <= `RST_REG8;
            pattern_sample_lower_q <= `RST_REG8;
            trigger_brake_duration_q <= `RST_REG8;
        end
        else if (reg_write)
        begin
            if (reg_addr == `OFS_PATTERN_ADDRESS)
            begin
                pattern_mem_address_q <= reg_wdata;
            end
            else if (reg_addr == `OFS_SAMPLE_UPPER)
            begin
                pattern_sample_upper_q <= reg_wdata;
            end
            else if (reg_addr == `OFS_SAMPLE_MIDDLE)
            begin
                pattern_sample_middle_q <= reg_wdata;
            end
            else if (reg_addr == `OFS_SAMPLE_LOWER)
            begin
                pattern_sample_lower_q <= reg_wdata;
            end
            else if (reg_addr == `OFS_BRAKE_DURATION)
            begin
                trigger_brake_duration_q <= reg_wdata;
            end
        end
    end

    // Writing the lower byte commits the staged sample at the selected address.
    always_ff @(posedge clk)
    begin
        if (reg_write && reg_addr == `OFS_SAMPLE_LOWER)
        begin
            mem_q[pattern_mem_address_q] <= {pattern_sample_upper_q,
                pattern_sample_middle_q, reg_wdata};
        end
    end

    // Read data is registered; unmapped offsets read as zero.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            reg_rdata <= 8'h00;
        end
        else if (reg_read)
        begin
            if (reg_addr == `OFS_PATTERN_ADDRESS)
            begin
                reg_rdata <= pattern_mem_address_q;
            end
            else if (reg_addr == `OFS_SAMPLE_UPPER)
            begin
                reg_rdata <= pattern_sample_upper_q;
            end
            else if (reg_addr == `OFS_SAMPLE_MIDDLE)
            begin
                reg_rdata <= pattern_sample_middle_q;
            end
            else if (reg_addr == `OFS_SAMPLE_LOWER)
            begin
                reg_rdata <= pattern_sample_lower_q;
            end
            else if (reg_addr == `OFS_BRAKE_DURATION)
            begin
                reg_rdata <= trigger_brake_duration_q;
            end
            else
            begin
                reg_rdata <= 8'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // Trigger input
    // ------------------------------------------------------------
    // Three-stage synchroniser; a level counts once stages two and three agree.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sync_q <= 3'h0;
            trig_level_q <= 1'b0;
        end
        else
        begin
            sync_q <= {sync_q[1:0], trigger_pin};
            if (sync_q[1] == sync_q[2])
            begin
                trig_level_q <= sync_q[2];
            end
        end
    end

    assign trig_rise = sync_q[1] && sync_q[2] && !trig_level_q;

    // ------------------------------------------------------------
    // Sample decode
    // ------------------------------------------------------------
    // Field split: upper byte chain/sign/amp high, middle amp low/duration/wait high.
    assign cur = mem_q[play_addr_q];
    assign nxt = mem_q[play_addr_q + 8'h01];
    assign cur_signed = cur.negative ? 8'(-{1'b0, cur.amplitude}) : {1'b0, cur.amplitude};
    assign nxt_signed = nxt.negative ? 8'(-{1'b0, nxt.amplitude}) : {1'b0, nxt.amplitude};
    assign mid_signed = 8'((9'({cur_signed[7], cur_signed}) +
        9'({nxt_signed[7], nxt_signed})) >> 1);
    assign auto_stop = !auto_brake_disable && motion_stopped;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Timer steps for the phase being entered next.
    always_comb
    begin
        tmr_load = 1'b0;
        tmr_steps = 8'h00;
        case (state_q)
            haptic_pattern_pkg::S_IDLE:
            begin
                tmr_load = trig_rise;
                tmr_steps = {3'h0, mem_q[pattern_mem_address_q][13:9]};
            end
            haptic_pattern_pkg::S_DRIVE:
            begin
                tmr_load = tmr_done;
                tmr_steps = {3'h0, cur.wait_steps};
            end
            haptic_pattern_pkg::S_WAIT:
            begin
                tmr_load = tmr_done;
                if (cur.chain == `CHAIN_MORE || cur.chain == `CHAIN_INTERP ||
                    (cur.chain == `CHAIN_REPEAT && rep_q < cur.repeat_count))
                begin
                    tmr_steps = cur.chain == `CHAIN_REPEAT ?
                        {3'h0, mem_q[start_addr_q][13:9]} : {3'h0, nxt.duration};
                end
                else
                begin
                    tmr_steps = trigger_brake_duration_q;
                end
            end
            default:
            begin
                tmr_load = 1'b0;
                tmr_steps = 8'h00;
            end
        endcase
    end

    // Walks the pattern, repeats it, then brakes in trigger mode.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q <= haptic_pattern_pkg::S_IDLE;
            play_addr_q <= 8'h00;
            start_addr_q <= 8'h00;
            rep_q <= 4'h0;
        end
        else
        begin
            case (state_q)
                haptic_pattern_pkg::S_IDLE:
                begin
                    if (trig_rise)
                    begin
                        play_addr_q <= pattern_mem_address_q;
                        start_addr_q <= pattern_mem_address_q;
                        rep_q <= 4'h0;
                        state_q <= haptic_pattern_pkg::S_DRIVE;
                    end
                end
                haptic_pattern_pkg::S_DRIVE:
                begin
                    if (tmr_done)
                    begin
                        state_q <= haptic_pattern_pkg::S_WAIT;
                    end
                end
                haptic_pattern_pkg::S_WAIT:
                begin
                    if (tmr_done)
                    begin
                        if (cur.chain == `CHAIN_MORE || cur.chain == `CHAIN_INTERP)
                        begin
                            play_addr_q <= play_addr_q + 8'h01;
                            state_q <= haptic_pattern_pkg::S_DRIVE;
                        end
                        else if (cur.chain == `CHAIN_REPEAT && rep_q < cur.repeat_count)
                        begin
                            rep_q <= rep_q + 4'h1;
                            play_addr_q <= start_addr_q;
                            state_q <= haptic_pattern_pkg::S_DRIVE;
                        end
                        else if (external_trigger_mode && trigger_brake_duration_q != 8'h00)
                        begin
                            state_q <= haptic_pattern_pkg::S_BRAKE;
                        end
                        else
                        begin
                            state_q <= haptic_pattern_pkg::S_IDLE;
                        end
                    end
                end
                default:
                begin
                    if (tmr_done || auto_stop)
                    begin
                        state_q <= haptic_pattern_pkg::S_IDLE;
                    end
                end
            endcase
        end
    end

    step_timer #(
        .STEP_CYCLES(STEP_CYCLES)
    ) u_timer (
        .clk(clk),
        .reset_n(reset_n),
        .load(tmr_load),
        .abort(state_q == haptic_pattern_pkg::S_BRAKE && auto_stop),
        .steps(tmr_steps),
        .done(tmr_done)
    );

    // Output drive: sample amplitude, midpoint when interpolating, brake level.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            drive_amplitude <= 7'h00;
            drive_negative <= 1'b0;
            braking <= 1'b0;
            busy <= 1'b0;
        end
        else
        begin
            busy <= state_q != haptic_pattern_pkg::S_IDLE;
            braking <= state_q == haptic_pattern_pkg::S_BRAKE;
            if (state_q == haptic_pattern_pkg::S_DRIVE && cur.chain == `CHAIN_INTERP)
            begin
                drive_negative <= mid_signed[7];
                drive_amplitude <= mid_signed[7] ? 7'(-mid_signed) : mid_signed[6:0];
            end
            else if (state_q == haptic_pattern_pkg::S_DRIVE)
            begin
                drive_negative <= cur.negative;
                drive_amplitude <= cur.amplitude;
            end
            else if (state_q == haptic_pattern_pkg::S_BRAKE)
            begin
                drive_negative <= trigger_brake_amplitude[7];
                drive_amplitude <= trigger_brake_amplitude[6:0];
            end
            else
            begin
                drive_negative <= 1'b0;
                drive_amplitude <= 7'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    sequence addr_write_s;
        reg_write && reg_addr == `OFS_PATTERN_ADDRESS;
    endsequence
    sequence wait_end_s;
        state_q == haptic_pattern_pkg::S_WAIT && tmr_done;
    endsequence

    addr_select_a: assert property (addr_write_s |=> pattern_mem_address_q == $past(reg_wdata))
        else $error("address register did not take the written value");
    sample_commit_a: assert property (reg_write && reg_addr == `OFS_SAMPLE_LOWER |=>
        mem_q[$past(pattern_mem_address_q)][7:0] == $past(reg_wdata))
        else $error("sample not committed at selected address");
    brake_needs_time_a: assert property ($rose(state_q == haptic_pattern_pkg::S_BRAKE) |->
        trigger_brake_duration_q != 8'h00 && $past(external_trigger_mode))
        else $error("brake entered without duration or trigger mode");
    auto_brake_stop_a: assert property (state_q == haptic_pattern_pkg::S_BRAKE && auto_stop |=>
        state_q == haptic_pattern_pkg::S_IDLE ##1 !braking)
        else $error("auto brake did not end on motion stop");
    chain_more_a: assert property (wait_end_s ##0 cur.chain == `CHAIN_MORE |=>
        state_q == haptic_pattern_pkg::S_DRIVE && play_addr_q == $past(play_addr_q) + 8'h01)
        else $error("chained sample did not advance");
    chain_last_a: assert property (wait_end_s ##0 cur.chain == `CHAIN_LAST |=>
        state_q inside {haptic_pattern_pkg::S_IDLE, haptic_pattern_pkg::S_BRAKE})
        else $error("last sample did not end the pattern");
    wait_zero_a: assert property (state_q == haptic_pattern_pkg::S_WAIT [*2] |->
        drive_amplitude == 7'h00 && !drive_negative)
        else $error("wait phase drove nonzero amplitude");
    brake_level_a: assert property (state_q == haptic_pattern_pkg::S_BRAKE |=>
        braking && drive_amplitude == $past(trigger_brake_amplitude[6:0])
        && drive_negative == $past(trigger_brake_amplitude[7]))
        else $error("brake amplitude or sign wrong");
    sample_level_a: assert property (state_q == haptic_pattern_pkg::S_DRIVE &&
        cur.chain != `CHAIN_INTERP |=> drive_amplitude == $past(cur.amplitude))
        else $error("sample amplitude not driven");
endmodule

/* core/step_timer.sv */
// Counts a number of 5 ms steps and pulses when they have elapsed.
`timescale 1ns/1ps
`include "haptic_pattern_consts.svh"
module step_timer #(
    parameter int STEP_CYCLES = `STEP_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic load,
    input wire logic abort,
    input wire logic [7:0] steps,
    output logic done
);
    logic [31:0] pre_q;
    logic [7:0] cnt_q;
    logic run_q;

    // A load restarts the count; one step passes every STEP_CYCLES edges.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pre_q <= 32'h0;
            cnt_q <= 8'h00;
            run_q <= 1'b0;
        end
        else if (load)
        begin
            pre_q <= 32'(STEP_CYCLES - 1);
            cnt_q <= steps;
            run_q <= 1'b1;
        end
        else if (abort || (run_q && cnt_q == 8'h00))
        begin
            run_q <= 1'b0;
        end
        else if (run_q)
        begin
            if (pre_q == 32'h0)
            begin
                pre_q <= 32'(STEP_CYCLES - 1);
                cnt_q <= cnt_q - 8'h01;
            end
            else
            begin
                pre_q <= pre_q - 32'h1;
            end
        end
    end

    // Done is a one-cycle pulse once the remaining count reaches zero.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            done <= 1'b0;
        end
        else
        begin
            done <= run_q && !load && !abort && cnt_q == 8'h00;
        end
    end
endmodule

/* shared/haptic_pattern_consts.svh */
// Register offsets, reset values and timing counts for the haptic pattern block.
`ifndef HAPTIC_PATTERN_CONSTS_SVH
`define HAPTIC_PATTERN_CONSTS_SVH
`define OFS_BRAKE_DURATION 8'h35
`define OFS_PATTERN_ADDRESS 8'h40
`define OFS_SAMPLE_UPPER 8'h41
`define OFS_SAMPLE_MIDDLE 8'h42
`define OFS_SAMPLE_LOWER 8'h43
`define RST_REG8 8'h00
`define CHAIN_LAST 2'h0
`define CHAIN_MORE 2'h1
`define CHAIN_INTERP 2'h2
`define CHAIN_REPEAT 2'h3
`define STEP_TIME_MS 5
`define CLK_RATE_KHZ 25000
`define STEP_CYCLES (`STEP_TIME_MS * `CLK_RATE_KHZ)
`endif

/* shared/haptic_pattern_pkg.sv */
// Types used by the haptic pattern player; the step timer uses none of them.
package haptic_pattern_pkg;
    // One decoded pattern sample, 24 bits as stored in pattern memory.
    typedef struct packed {
        logic [1:0] chain;
        logic negative;
        logic [6:0] amplitude;
        logic [4:0] duration;
        logic [4:0] wait_steps;
        logic [3:0] repeat_count;
    } sample_t;

    // Player sequence states.
    typedef enum logic [1:0] {
        S_IDLE,
        S_DRIVE,
        S_WAIT,
        S_BRAKE
    } play_state_t;
endpackage

/* sim/haptic_pattern_ram_brake_tb_top.sv */
// Self-checking testbench for the haptic pattern player and its trigger braking.
`timescale 1ns/1ps
`include "haptic_pattern_consts.svh"
`define CHK(what, exp, got) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) \
        begin \
            n_mismatch++; \
            $display("ERROR %s expected %0h seen %0h", what, exp, got); \
        end \
    end
module haptic_pattern_ram_brake_tb_top;
    // ----------------------------------------
    // Clock, reset and design hookup
    // ----------------------------------------
    // Short step so that a 5 ms unit costs four clocks.
    localparam int STEP = 4;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, brake_amp;
    logic reg_write, reg_read, trigger_pin, ext_mode, abd, stopped;
    logic [6:0] drive_amplitude;
    logic drive_negative, braking, busy;
    int n_mismatch = 0;
    int comparisons = 0;
    int seed = 32'h3dc5;
    int drv_cyc, brk_cyc, busy_cyc;
    logic [7:0] brk_val, got, a, bd;
    logic [7:0] segs[$];
    logic [6:0] amp0, amp1;
    logic neg0;
    int rep;
    logic [7:0] ofs[4] = '{`OFS_PATTERN_ADDRESS, `OFS_SAMPLE_UPPER, `OFS_SAMPLE_MIDDLE,
        `OFS_BRAKE_DURATION};

    // The clock toggles every 20 ns, half of its 40 ns period.
    always #20 clk = ~clk;

    haptic_pattern_player #(
        .STEP_CYCLES(STEP),
        .DEPTH(256)
    ) haptic_pattern_player_i (
        .clk(clk),
        .reset_n(reset_n),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_write(reg_write),
        .reg_read(reg_read),
        .reg_rdata(reg_rdata),
        .trigger_pin(trigger_pin),
        .external_trigger_mode(ext_mode),
        .auto_brake_disable(abd),
        .trigger_brake_amplitude(brake_amp),
        .motion_stopped(stopped),
        .drive_amplitude(drive_amplitude),
        .drive_negative(drive_negative),
        .braking(braking),
        .busy(busy)
    );

    // ----------------------------------------
    // Bus and pattern tasks
    // ----------------------------------------
    // Every task starts and ends one nanosecond after a rising edge.
    task automatic tally_and_finish();
        $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        reg_addr = ad;
        reg_wdata = d;
        reg_write = 1'b1;
        @(posedge clk);
        #1;
        reg_write = 1'b0;
        // One idle edge keeps the strobe from falling and rising in one step.
        @(posedge clk);
        #1;
    endtask

    task automatic rd(input logic [7:0] ad, output logic [7:0] d);
        reg_addr = ad;
        reg_read = 1'b1;
        @(posedge clk);
        #1;
        reg_read = 1'b0;
        @(posedge clk);
        #1;
        d = reg_rdata;
    endtask

    // Packs the sample fields into the three data bytes; the lower byte commits it.
    task automatic store(input logic [7:0] ad, input logic [1:0] ch, input logic neg,
        input logic [6:0] amp, input logic [4:0] dur, input logic [4:0] wt,
        input logic [3:0] rp);
        wr(`OFS_PATTERN_ADDRESS, ad);
        wr(`OFS_SAMPLE_UPPER, {ch, neg, amp[6:2]});
        wr(`OFS_SAMPLE_MIDDLE, {amp[1:0], dur, wt[4]});
        wr(`OFS_SAMPLE_LOWER, {wt[3:0], rp});
    endtask

    // Fires the trigger and records drive segments, drive, brake and busy cycle counts.
    task automatic play();
        int k;
        int idle;
        logic on_q;
        segs.delete();
        drv_cyc = 0;
        brk_cyc = 0;
        busy_cyc = 0;
        idle = 0;
        on_q = 1'b0;
        trigger_pin = 1'b1;
        for (k = 0; k < 4000 && idle < 3; k++)
        begin
            @(posedge clk);
            #1;
            if (k == 3)
                trigger_pin = 1'b0;
            if (busy === 1'b1)
                busy_cyc++;
            else if (busy_cyc > 0)
                idle++;
            if (braking === 1'b1)
            begin
                brk_cyc++;
                brk_val = {drive_negative, drive_amplitude};
            end
            else if (drive_amplitude !== 7'h00 && !on_q)
                segs.push_back({drive_negative, drive_amplitude});
            if (braking !== 1'b1 && drive_amplitude !== 7'h00)
                drv_cyc++;
            on_q = (braking !== 1'b1) && (drive_amplitude !== 7'h00);
            if (k == 40 && busy_cyc == 0)
                break;
        end
        if (idle < 3)
        begin
            n_mismatch++;
            $display("ERROR pattern run did not complete in time");
            tally_and_finish();
        end
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        {reg_addr, reg_wdata, reg_write, reg_read, trigger_pin} = '0;
        {ext_mode, abd, stopped, brake_amp} = '0;
        repeat (8) @(posedge clk);
        #1;
        reset_n = 1'b1;
        // Register reset values, then an unmapped offset.
        foreach (ofs[j])
        begin
            rd(ofs[j], got);
            `CHK("reset value", `RST_REG8, got)
        end
        rd(8'h77, got);
        `CHK("unmapped read", 8'h00, got)
        // Random write and read back of every register except the lower sample byte.
        repeat (8)
        begin
            foreach (ofs[j])
            begin
                bd = 8'($random(seed));
                wr(ofs[j], bd);
                rd(ofs[j], got);
                `CHK("read back", bd, got)
            end
        end
        // Two chained samples at a random place, started from a rewound address.
        a = 8'($unsigned($random(seed)) % 200);
        amp0 = 7'($random(seed)) | 7'h01;
        amp1 = amp0 ^ 7'h40;
        neg0 = 1'($random(seed));
        store(a, `CHAIN_MORE, neg0, amp0, 5'h02, 5'h01, 4'h0);
        store(8'(a + 8'h01), `CHAIN_LAST, ~neg0, amp1, 5'h03, 5'h01, 4'h0);
        store(8'(a + 8'h02), `CHAIN_LAST, 1'b0, 7'h7F, 5'h04, 5'h01, 4'h0);
        wr(`OFS_PATTERN_ADDRESS, a);
        play();
        `CHK("segment count", 2, segs.size())
        `CHK("first sample", {neg0, amp0}, segs[0])
        `CHK("second sample", {~neg0, amp1}, segs[1])
        `CHK("drive cycles", 1'b1, drv_cyc + 2 >= 5 * STEP && drv_cyc <= 5 * STEP + 6)
        `CHK("busy cycles", 1'b1, busy_cyc >= 7 * STEP && busy_cyc <= 7 * STEP + 12)
        `CHK("no brake", 0, brk_cyc)
        // Last sample with repeat restarts at the start address.
        rep = $unsigned($random(seed)) % 4;
        store(a, `CHAIN_REPEAT, 1'b1, 7'h33, 5'h01, 5'h01, 4'(rep));
        play();
        `CHK("repeat segments", rep + 1, segs.size())
        `CHK("repeat sample", 8'hB3, segs[0])
        // Interpolation drives the midpoint toward the next sample.
        store(a, `CHAIN_INTERP, 1'b0, 7'd40, 5'h02, 5'h01, 4'h0);
        store(8'(a + 8'h01), `CHAIN_LAST, 1'b0, 7'd20, 5'h02, 5'h01, 4'h0);
        wr(`OFS_PATTERN_ADDRESS, a);
        play();
        `CHK("interp midpoint", 8'd30, segs[0])
        `CHK("interp target", 8'd20, segs[1])
        // Trigger braking: host-tuned length, then the automatic cap with motion stop.
        store(a, `CHAIN_LAST, 1'b0, 7'h20, 5'h01, 5'h01, 4'h0);
        ext_mode = 1'b1;
        brake_amp = 8'($random(seed)) | 8'h01;
        wr(`OFS_BRAKE_DURATION, 8'h05);
        abd = 1'b1;
        stopped = 1'b1;
        play();
        `CHK("brake length", 1'b1, brk_cyc + 1 >= 5 * STEP && brk_cyc <= 5 * STEP + 3)
        `CHK("brake drive", brake_amp, brk_val)
        abd = 1'b0;
        stopped = 1'b0;
        play();
        `CHK("auto brake cap", 1'b1, brk_cyc + 1 >= 5 * STEP && brk_cyc <= 5 * STEP + 3)
        stopped = 1'b1;
        play();
        `CHK("auto brake stop", 1'b1, brk_cyc >= 1 && brk_cyc <= 3)
        tally_and_finish();
    end
endmodule
